// ==== core/ctr_map.svh ====
// Register offsets, reset values and sizes of the edge separation and encoder counter.
// Assumes inclusion by bare name from the package and the design module.
`ifndef CTR_MAP_SVH
`define CTR_MAP_SVH

// Byte offsets of the register words on the bus.
`define CTR_OFF_CTRL 8'h00
`define CTR_OFF_SEL 8'h04
`define CTR_OFF_RELOAD 8'h08
`define CTR_OFF_INIT 8'h0c
`define CTR_OFF_RESULT 8'h10
`define CTR_OFF_STATUS 8'h14
`define CTR_OFF_FIFO 8'h18
`define CTR_OFF_FILTER 8'h1c

// Reset values: rising edges, software start, internal timebase, filter off.
`define CTR_CTRL_RESET 16'h0000
`define CTR_SEL_RESET 16'h7d63
`define CTR_FILT_RESET 4'h3

// Input terminals and the fixed encoder channel positions.
`define CTR_NUM_TERM 8
`define CTR_TERM_SEL_W 3
`define CTR_TERM_A 3'h0
`define CTR_TERM_B 3'h1
`define CTR_TERM_Z 3'h2

// Result buffer geometry and the status bit that clears the overflow flag.
`define CTR_FIFO_DEPTH 5'h10
`define CTR_FIFO_AW 4
`define CTR_STS_OVF_BIT 2

`endif

// ==== core/ctr_pkg.sv ====
// Types shared by the counter design and its bench.
// Assumes the constant header is on the include path.
`include "ctr_map.svh"

package ctr_pkg;

  // Measurement state; the usual path walks a Gray sequence.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ARM = 3'h1,
    ST_WAIT_BEGIN = 3'h3,
    ST_MEASURE = 3'h2,
    ST_HOLD = 3'h6,
    ST_RUN = 3'h7
  } run_state_t;

  typedef enum logic [1:0] {
    TM_ON_DEMAND = 2'h0,
    TM_IMPLICIT = 2'h1,
    TM_SAMPLE = 2'h2,
    TM_SPARE = 2'h3
  } timing_t;

  typedef enum logic [1:0] {
    DEC_X1 = 2'h0,
    DEC_X2 = 2'h1,
    DEC_X4 = 2'h2,
    DEC_TWO_PULSE = 2'h3
  } decode_t;

  // Control word, bit 0 first from the bottom.
  typedef struct packed {
    logic filter_en;
    logic timebase_select;
    logic sample_edge;
    logic [1:0] index_phase;
    logic index_en;
    logic arm_edge;
    logic arm_en;
    logic end_edge_polarity;
    logic begin_edge_polarity;
    decode_t decode;
    timing_t timing;
    logic pos_mode;
    logic start;
  } ctrl_t;

  // Terminal selection word.
  typedef struct packed {
    logic spare;
    logic [`CTR_TERM_SEL_W-1:0] tb_source;
    logic [`CTR_TERM_SEL_W-1:0] sample_source;
    logic [`CTR_TERM_SEL_W-1:0] arm_source;
    logic [`CTR_TERM_SEL_W-1:0] end_input_select;
    logic [`CTR_TERM_SEL_W-1:0] begin_input_select;
  } sel_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } ahb_rsp_t;

  // Every flip-flop of the counter.
  typedef struct packed {
    ctrl_t ctrl;
    sel_t sel;
    logic [31:0] reload;
    logic [31:0] init;
    logic [3:0] filt_len;
    logic [`CTR_NUM_TERM-1:0] sync1;
    logic [`CTR_NUM_TERM-1:0] sync2;
    logic [`CTR_NUM_TERM-1:0] filt;
    logic [`CTR_NUM_TERM-1:0] prev;
    logic [`CTR_NUM_TERM-1:0][3:0] fcnt;
    run_state_t fsm;
    logic [31:0] count;
    logic [31:0] interval;
    logic [31:0] result;
    logic [31:0] latest;
    logic latest_valid;
    logic [15:0][31:0] fifo_mem;
    logic [`CTR_FIFO_AW-1:0] wp;
    logic [`CTR_FIFO_AW-1:0] rp;
    logic [4:0] fcount;
    logic overflow;
    logic wr_pend;
    logic [7:0] wr_addr;
    ahb_rsp_t rsp;
  } state_t;

endpackage

// ==== core/edge_sep_encoder_counter.sv ====
// Edge separation timer and quadrature or two-pulse position counter with an AHB-Lite slave.
// Assumes one 100 MHz clock, a synchronous reset and asynchronous pins on the input terminals.
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
`include "ctr_map.svh"

module edge_sep_encoder_counter (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register bus.
  input wire ctr_pkg::ahb_req_t ahb_req,
  output ctr_pkg::ahb_rsp_t ahb_rsp,
  // Counter input terminals.
  input wire logic [`CTR_NUM_TERM-1:0] external_input_terminal
);
  import ctr_pkg::*;

  state_t s;
  state_t next_s;
  logic [`CTR_NUM_TERM-1:0] rise;
  logic [`CTR_NUM_TERM-1:0] fall;
  logic tick, a, b, z, a_r, a_f, b_r, b_f;
  logic begin_hit, end_hit, arm_hit, samp_hit;
  logic step_up, step_dn, idx_cond;
  logic acc, rd, pop, push, full, drop, rd_result, ctrl_wr, start_rise;
  logic [31:0] push_data;
  logic [31:0] measured;
  logic [7:0] raddr;
  ctrl_t wctrl;

  // Picks the rising or falling edge of one selected terminal.
  function automatic logic edge_hit(input logic [`CTR_NUM_TERM-1:0] r,
                                    input logic [`CTR_NUM_TERM-1:0] f,
                                    input logic [`CTR_TERM_SEL_W-1:0] sel,
                                    input logic fall_sel);
    edge_hit = fall_sel ? f[sel] : r[sel];
  endfunction

  // Whole next-state computation: pins, bus, measurement, decoder and buffer.
  always_comb begin
    next_s = s;
    rise = s.filt & ~s.prev;
    fall = ~s.filt & s.prev;
    a = s.filt[`CTR_TERM_A];
    b = s.filt[`CTR_TERM_B];
    z = s.filt[`CTR_TERM_Z];
    a_r = rise[`CTR_TERM_A];
    a_f = fall[`CTR_TERM_A];
    b_r = rise[`CTR_TERM_B];
    b_f = fall[`CTR_TERM_B];
    push = 1'b0;
    push_data = 32'h0;
    measured = 32'h0;

    // Two flops before any logic; sync1 is read by sync2 alone.
    next_s.sync1 = external_input_terminal;
    next_s.sync2 = s.sync1;
    next_s.prev = s.filt;
    // A change must persist filt_len+1 cycles before the filter passes it on.
    for (int i = 0; i < `CTR_NUM_TERM; i++) begin
      if (!s.ctrl.filter_en) begin
        next_s.filt[i] = s.sync2[i];
        next_s.fcnt[i] = 4'h0;
      end else if (s.sync2[i] == s.filt[i]) begin
        next_s.fcnt[i] = 4'h0;
      end else if (s.fcnt[i] == s.filt_len) begin
        next_s.filt[i] = s.sync2[i];
        next_s.fcnt[i] = 4'h0;
      end else begin
        next_s.fcnt[i] = s.fcnt[i] + 4'h1;
      end
    end

    // Timebase is every clock, or rising edges of a chosen terminal.
    // An external timebase passes the same pin delay as the begin and end inputs.
    tick = s.ctrl.timebase_select ? rise[s.sel.tb_source] : 1'b1;
    begin_hit = edge_hit(rise, fall, s.sel.begin_input_select, s.ctrl.begin_edge_polarity);
    end_hit = edge_hit(rise, fall, s.sel.end_input_select, s.ctrl.end_edge_polarity);
    arm_hit = edge_hit(rise, fall, s.sel.arm_source, s.ctrl.arm_edge);
    samp_hit = edge_hit(rise, fall, s.sel.sample_source, s.ctrl.sample_edge)
               && (s.ctrl.timing == TM_SAMPLE);

    // Quadrature direction comes from the level of the other channel at each edge.
    step_up = 1'b0;
    step_dn = 1'b0;
    case (s.ctrl.decode)
      DEC_X1: begin
        step_up = a_r & ~b;
        step_dn = a_f & ~b;
      end
      DEC_X2: begin
        step_up = (a_r & ~b) | (a_f & b);
        step_dn = (a_r & b) | (a_f & ~b);
      end
      DEC_X4: begin
        step_up = (a_r & ~b) | (a_f & b) | (b_r & a) | (b_f & ~a);
        step_dn = (a_r & b) | (a_f & ~b) | (b_r & ~a) | (b_f & a);
      end
      default: begin
        step_up = a_r;
        step_dn = b_r;
      end
    endcase
    idx_cond = s.ctrl.index_en && ({a, b} == s.ctrl.index_phase) && z;

    // Bus address phase: zero wait states, read data registered into the data phase.
    acc = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
    rd = acc && !ahb_req.hwrite;
    raddr = ahb_req.haddr[7:0];
    pop = rd && (raddr == `CTR_OFF_FIFO) && (s.fcount != 5'h0);
    rd_result = rd && (raddr == `CTR_OFF_RESULT);
    next_s.wr_pend = acc && ahb_req.hwrite;
    next_s.wr_addr = raddr;
    if (!rd) begin
      next_s.rsp.hrdata = 32'h0;
    end else if (raddr == `CTR_OFF_CTRL) begin
      next_s.rsp.hrdata = {16'h0, s.ctrl};
    end else if (raddr == `CTR_OFF_SEL) begin
      next_s.rsp.hrdata = {16'h0, s.sel};
    end else if (raddr == `CTR_OFF_RELOAD) begin
      next_s.rsp.hrdata = s.reload;
    end else if (raddr == `CTR_OFF_INIT) begin
      next_s.rsp.hrdata = s.init;
    end else if (raddr == `CTR_OFF_RESULT) begin
      next_s.rsp.hrdata = s.ctrl.pos_mode ? s.count : s.result;
    end else if (raddr == `CTR_OFF_STATUS) begin
      next_s.rsp.hrdata = {24'h0, s.fcount, s.overflow, s.fsm == ST_HOLD, s.fsm != ST_IDLE};
    end else if (raddr == `CTR_OFF_FIFO) begin
      next_s.rsp.hrdata = pop ? s.fifo_mem[s.rp] : 32'h0;
    end else if (raddr == `CTR_OFF_FILTER) begin
      next_s.rsp.hrdata = {28'h0, s.filt_len};
    end else begin
      next_s.rsp.hrdata = 32'h0;
    end
    next_s.rsp.hreadyout = 1'b1;
    next_s.rsp.hresp = 1'b0;

    // Bus data phase: writes land one cycle after their address.
    wctrl = ctrl_t'(ahb_req.hwdata[15:0]);
    ctrl_wr = s.wr_pend && (s.wr_addr == `CTR_OFF_CTRL);
    start_rise = ctrl_wr && wctrl.start && !s.ctrl.start;
    if (ctrl_wr) begin
      next_s.ctrl = wctrl;
    end else if (s.wr_pend && (s.wr_addr == `CTR_OFF_SEL)) begin
      next_s.sel = sel_t'(ahb_req.hwdata[15:0]);
    end else if (s.wr_pend && (s.wr_addr == `CTR_OFF_RELOAD)) begin
      next_s.reload = ahb_req.hwdata;
    end else if (s.wr_pend && (s.wr_addr == `CTR_OFF_INIT)) begin
      next_s.init = ahb_req.hwdata;
    end else if (s.wr_pend && (s.wr_addr == `CTR_OFF_FILTER)) begin
      next_s.filt_len = ahb_req.hwdata[3:0];
    end else if (s.wr_pend && (s.wr_addr == `CTR_OFF_STATUS)
                 && ahb_req.hwdata[`CTR_STS_OVF_BIT]) begin
      next_s.overflow = 1'b0;
    end

    // Measurement and position state machine.
    case (s.fsm)
      ST_IDLE: begin
      end
      ST_ARM: begin
        if (arm_hit) begin
          next_s.fsm = s.ctrl.pos_mode ? ST_RUN : ST_WAIT_BEGIN;
        end
      end
      ST_WAIT_BEGIN: begin
        if (begin_hit) begin
          next_s.interval = 32'h0;
          next_s.fsm = ST_MEASURE;
        end
      end
      ST_MEASURE: begin
        // The end edge's own tick counts, so a result spans begin exclusive to end inclusive.
        measured = s.interval + {31'h0, tick};
        if (end_hit) begin
          next_s.fsm = ST_WAIT_BEGIN;
          if (s.ctrl.timing == TM_IMPLICIT) begin
            push = 1'b1;
            push_data = measured;
          end else if (s.ctrl.timing == TM_SAMPLE) begin
            next_s.latest = measured;
            next_s.latest_valid = 1'b1;
          end else begin
            next_s.result = measured;
            next_s.fsm = ST_HOLD;
          end
        end else if (tick) begin
          next_s.interval = measured;
        end
      end
      ST_HOLD: begin
        // Inputs are not looked at until software takes the held result.
        if (rd_result) begin
          next_s.fsm = ST_WAIT_BEGIN;
        end
      end
      ST_RUN: begin
        // A step wins a tie with the reload; the reload then lands next cycle.
        if (step_up && !step_dn) begin
          next_s.count = s.count + 32'h1;
        end else if (step_dn && !step_up) begin
          next_s.count = s.count - 32'h1;
        end else if (idx_cond) begin
          next_s.count = s.reload;
        end
      end
      default: begin
        next_s.fsm = ST_IDLE;
      end
    endcase

    // Sample clock captures position, or the last completed separation.
    if (samp_hit && (s.fsm == ST_RUN)) begin
      push = 1'b1;
      push_data = s.count;
    end else if (samp_hit && s.latest_valid
                 && ((s.fsm == ST_WAIT_BEGIN) || (s.fsm == ST_MEASURE))) begin
      push = 1'b1;
      push_data = s.latest;
    end

    // Result buffer; a pop in the same cycle makes room for a push.
    // Sixteen words absorb bursts; software that falls behind loses the newest results.
    full = (s.fcount == `CTR_FIFO_DEPTH);
    drop = push && full && !pop;
    if (push && !drop) begin
      next_s.fifo_mem[s.wp] = push_data;
      next_s.wp = s.wp + {{(`CTR_FIFO_AW-1){1'b0}}, 1'b1};
    end
    if (pop) begin
      next_s.rp = s.rp + {{(`CTR_FIFO_AW-1){1'b0}}, 1'b1};
    end
    next_s.fcount = s.fcount + {4'h0, push && !drop} - {4'h0, pop};
    // Set is applied after the software clear so a coinciding drop is kept.
    if (drop) begin
      next_s.overflow = 1'b1;
    end

    // Start reloads the count and state and empties the buffer, keeping the overflow flag; clearing start stops the counter.
    if (start_rise) begin
      next_s.count = s.init;
      next_s.wp = {`CTR_FIFO_AW{1'b0}};
      next_s.rp = {`CTR_FIFO_AW{1'b0}};
      next_s.fcount = 5'h0;
      next_s.latest_valid = 1'b0;
      if (wctrl.arm_en) begin
        next_s.fsm = ST_ARM;
      end else begin
        next_s.fsm = wctrl.pos_mode ? ST_RUN : ST_WAIT_BEGIN;
      end
    end else if (ctrl_wr && !wctrl.start) begin
      next_s.fsm = ST_IDLE;
    end
  end

  // The single state register.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s <= '0;
      s.ctrl <= ctrl_t'(`CTR_CTRL_RESET);
      s.sel <= sel_t'(`CTR_SEL_RESET);
      s.filt_len <= `CTR_FILT_RESET;
      s.rsp.hreadyout <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign ahb_rsp = s.rsp;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Separation checks.
  sequence seq_end_on_demand;
    (s.fsm == ST_MEASURE) && end_hit && (s.ctrl.timing == TM_ON_DEMAND) && !ctrl_wr;
  endsequence

  a_sep_interval: assert property (seq_end_on_demand |=> (s.fsm == ST_HOLD) &&
    (s.result == $past(s.interval) + {31'h0, $past(tick)}))
    else $error("separation result does not match the timed interval");
  a_begin_rising: assert property ((s.fsm == ST_WAIT_BEGIN) && !ctrl_wr &&
    !s.ctrl.begin_edge_polarity && rise[s.sel.begin_input_select]
    |=> (s.fsm == ST_MEASURE) && (s.interval == 32'h0))
    else $error("rising begin edge did not start a measurement");
  a_hold_ignores: assert property ((s.fsm == ST_HOLD) && !rd_result && !ctrl_wr
    |=> (s.fsm == ST_HOLD) && $stable(s.result))
    else $error("held result left before it was read");
  a_hold_release: assert property ((s.fsm == ST_HOLD) && rd_result && !ctrl_wr
    |=> s.fsm == ST_WAIT_BEGIN)
    else $error("reading the result did not rearm the measurement");
  a_implicit_push: assert property ((s.fsm == ST_MEASURE) && end_hit && !ctrl_wr &&
    (s.ctrl.timing == TM_IMPLICIT) && !full && !pop
    |=> (s.fcount == $past(s.fcount) + 5'h1) && (s.fsm == ST_WAIT_BEGIN))
    else $error("implicit result was not buffered");
  a_sample_latest: assert property (samp_hit && s.latest_valid && !full && !ctrl_wr &&
    ((s.fsm == ST_WAIT_BEGIN) || (s.fsm == ST_MEASURE))
    |=> s.fifo_mem[$past(s.wp)] == $past(s.latest))
    else $error("sample edge stored the wrong separation");
  a_arm_wait: assert property ((s.fsm == ST_ARM) && !arm_hit && !ctrl_wr
    |=> s.fsm == ST_ARM)
    else $error("counter started without its arm edge");
  a_tick_gate: assert property ((s.fsm == ST_MEASURE) && !end_hit && !tick && !ctrl_wr
    |=> $stable(s.interval))
    else $error("interval advanced without a timebase tick");

  // Position checks, then the synchroniser and buffer overflow checks.
  sequence seq_step_in_phase;
    (s.fsm == ST_RUN) && idx_cond && (step_up != step_dn) && !ctrl_wr;
  endsequence
  sequence seq_still_in_phase;
    (s.fsm == ST_RUN) && idx_cond && (step_up == step_dn) && !ctrl_wr;
  endsequence

  a_x1_up: assert property ((s.fsm == ST_RUN) && (s.ctrl.decode == DEC_X1) && a_r &&
    !b && !ctrl_wr |=> s.count == $past(s.count) + 32'h1)
    else $error("X1 rising A with A leading did not count up");
  a_x2_a_fall: assert property ((s.fsm == ST_RUN) && (s.ctrl.decode == DEC_X2) && a_f &&
    b && !ctrl_wr |=> s.count == $past(s.count) + 32'h1)
    else $error("X2 falling A with A leading did not count up");
  a_x4_b_down: assert property ((s.fsm == ST_RUN) && (s.ctrl.decode == DEC_X4) && b_r &&
    a_r == 1'b0 && a_f == 1'b0 && !a && !ctrl_wr |=> s.count == $past(s.count) - 32'h1)
    else $error("X4 rising B with B leading did not count down");
  a_two_pulse_down: assert property ((s.fsm == ST_RUN) &&
    (s.ctrl.decode == DEC_TWO_PULSE) && b_r && !a_r && !ctrl_wr
    |=> s.count == $past(s.count) - 32'h1)
    else $error("two-pulse B edge did not count down");
  a_step_then_reload: assert property (seq_step_in_phase ##1 seq_still_in_phase
    |=> s.count == $past(s.reload))
    else $error("reload did not follow the coinciding step");
  a_reload_bound: assert property (((s.fsm == ST_RUN) && idx_cond && !ctrl_wr) [*2]
    |=> s.count == $past(s.reload))
    else $error("index reload was late");
  a_read_no_disturb: assert property ((s.fsm == ST_RUN) && rd_result && !step_up &&
    !step_dn && !idx_cond && !ctrl_wr |=> $stable(s.count))
    else $error("position read disturbed the count");
  a_pos_sample: assert property (samp_hit && (s.fsm == ST_RUN) && !full && !ctrl_wr
    |=> s.fifo_mem[$past(s.wp)] == $past(s.count))
    else $error("sample edge stored the wrong position");
  a_start_init: assert property (start_rise
    |=> (s.count == $past(s.init)) && (s.fcount == 5'h0))
    else $error("start did not load the initial position");
  a_sync_two_stage: assert property ($past(rst_n) && $past(rst_n, 2)
    |-> s.sync2 == $past(external_input_terminal, 2))
    else $error("terminal did not pass two synchroniser stages");
  a_overflow_drop: assert property (drop && !ctrl_wr
    |=> s.overflow && (s.fcount == $past(s.fcount)))
    else $error("full buffer overflow not flagged or not dropped");

endmodule

// ==== dv/encoder_source.sv ====
// Encoder and edge source model that drives the counter's input terminals.
// Assumes the bench calls its tasks from one process, right after a rising edge.
`timescale 1ns/1ns

module encoder_source (
  // Clock.
  input wire logic ref_clk,
  // Terminals: 0 is A, 1 is B, 2 is the index, the rest are plain edge sources.
  output logic [7:0] term
);

  // Quadrature phase index; the levels are {A,B} = 00, 10, 11, 01.
  logic [1:0] ph;

  // Every terminal starts low, which is phase 00.
  initial begin
    term = 8'h00;
    ph = 2'h0;
  end

  // One quadrature step; up means A leads B. Only one of A and B changes per step.
  task automatic quad(input logic up, input int gap);
    ph = up ? ph + 2'h1 : ph - 2'h1;
    @(posedge ref_clk);
    term[0] <= ph[0] ^ ph[1];
    term[1] <= ph[1];
    repeat (gap) @(posedge ref_clk);
  endtask

  // Sets one terminal and lets gap cycles pass, so slow and prompt sources both occur.
  task automatic put(input int idx, input logic v, input int gap);
    @(posedge ref_clk);
    term[idx] <= v;
    repeat (gap) @(posedge ref_clk);
  endtask

endmodule

// ==== dv/edge_separation_and_encoder_counter_tb.sv ====
// Self-checking bench for the edge separation and encoder counter.
// Assumes the encoder_source model on the terminals and this bench as the only bus master.
`timescale 1ns/1ns

module edge_separation_and_encoder_counter_tb;
  import ctr_pkg::*;

  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  ahb_req_t drv = '0;
  ahb_req_t req;
  ahb_rsp_t rsp;
  logic [7:0] term;
  logic [31:0] seed = 32'hc212;
  logic [31:0] exp_val;
  logic [31:0] rd;
  logic [31:0] q[$];
  int n_mismatch = 0;
  int n_tests = 0;
  ctrl_t c;

  // The master's hready is the one slave's hreadyout.
  always_comb begin
    req = drv;
    req.hready = rsp.hreadyout;
  end

  edge_sep_encoder_counter edge_sep_encoder_counter_inst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ahb_req(req),
    .ahb_rsp(rsp),
    .external_input_terminal(term)
  );

  encoder_source encoder_source_inst (.ref_clk(ref_clk), .term(term));

  // 100 MHz clock.
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // Prints the verdict and ends the run.
  task automatic close_out();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Xorshift source, so every run sees the same values.
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  // Waits for hready at a rising edge; a slave that never answers ends the run.
  task automatic rdy();
    int i;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (rsp.hreadyout !== 1'b1 && i < 50);
    if (rsp.hreadyout !== 1'b1) begin
      n_mismatch++;
      close_out();
    end
  endtask

  // One single word transfer; read data is taken at the edge that ends the data phase.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    drv.hsel <= 1'b1;
    drv.haddr <= {24'h0, a};
    drv.htrans <= 2'h2;
    drv.hwrite <= w;
    drv.hsize <= 3'h2;
    rdy();
    drv.hsel <= 1'b0;
    drv.htrans <= 2'h0;
    drv.hwdata <= wd;
    rdy();
    rd = rsp.hrdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
    bus(a, 1'b0, 32'h0);
    chk({31'h0, rsp.hresp}, 32'h0);
    chk(rd, want);
  endtask

  // Stop first, since only a 0 to 1 change of start restarts the counter.
  task automatic run(input ctrl_t cc, input logic [31:0] init);
    bus(8'h00, 1'b1, 32'h0);
    bus(8'h0c, 1'b1, init);
    bus(8'h00, 1'b1, {16'h0, cc});
  endtask

  // Begin edge, k cycles later the end edge, then both back to the idle level.
  task automatic sep(input int k, input logic pol);
    encoder_source_inst.put(3, ~pol, k - 1);
    encoder_source_inst.put(4, ~pol, 6);
    encoder_source_inst.put(3, pol, 0);
    encoder_source_inst.put(4, pol, 6);
  endtask

  // Quadrature step; the expected count moves only where the decode mode steps.
  task automatic qstep(input logic up, input decode_t d);
    logic [1:0] f;
    logic [1:0] t;
    f = encoder_source_inst.ph;
    t = up ? f + 2'h1 : f - 2'h1;
    if (d == DEC_X4 || (^f != ^t && (d == DEC_X2 || !t[1]))) begin
      exp_val = up ? exp_val + 32'h1 : exp_val - 32'h1;
    end
    encoder_source_inst.quad(up, 5 + int'(xs() % 6));
  endtask

  // Main sequence: reset values, position modes, index reload, then separation modes.
  initial begin
    int i;
    int k;
    int d;
    logic [31:0] rl;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdchk(8'h00, 32'h0);
    rdchk(8'h04, 32'h7d63);
    rdchk(8'h1c, 32'h3);
    rdchk(8'h20, 32'h0);
    c = '0;
    c.start = 1'b1;
    c.pos_mode = 1'b1;
    c.decode = DEC_TWO_PULSE;
    exp_val = xs();
    run(c, exp_val);
    repeat (10) begin
      i = int'(xs() % 2);
      encoder_source_inst.put(i, 1'b1, 5);
      encoder_source_inst.put(i, 1'b0, 5);
      exp_val = (i == 0) ? exp_val + 32'h1 : exp_val - 32'h1;
      rdchk(8'h10, exp_val);
    end
    // Each quadrature walk ends with a sample edge that copies the count.
    for (d = 0; d < 3; d++) begin
      c.decode = decode_t'(d);
      c.timing = TM_SAMPLE;
      exp_val = xs();
      run(c, exp_val);
      repeat (12) begin
        qstep(xs() % 2 == 0, c.decode);
        rdchk(8'h10, exp_val);
      end
      encoder_source_inst.put(6, 1'b1, 6);
      encoder_source_inst.put(6, 1'b0, 6);
      rdchk(8'h18, exp_val);
    end
    // Index reload in phase 00, entered by a step while the index is high.
    while (encoder_source_inst.ph != 2'h0) qstep(1'b1, DEC_X4);
    c.index_en = 1'b1;
    c.timing = TM_ON_DEMAND;
    rl = xs();
    bus(8'h08, 1'b1, rl);
    exp_val = 32'hffff_ffff;
    run(c, exp_val);
    qstep(1'b1, DEC_X4);
    rdchk(8'h10, exp_val);
    encoder_source_inst.put(2, 1'b1, 4);
    repeat (3) qstep(1'b1, DEC_X4);
    rdchk(8'h10, rl);
    encoder_source_inst.put(2, 1'b0, 4);
    exp_val = rl;
    qstep(1'b1, DEC_X4);
    rdchk(8'h10, exp_val);
    // On-demand separation behind an arm edge; pairs before arm and while held are ignored.
    c = '0;
    c.start = 1'b1;
    c.arm_en = 1'b1;
    run(c, 32'h0);
    sep(9, 1'b0);
    encoder_source_inst.put(5, 1'b1, 6);
    k = 3 + int'(xs() % 16);
    sep(k, 1'b0);
    sep(20, 1'b0);
    rdchk(8'h14, 32'h3);
    rdchk(8'h10, k);
    k = 3 + int'(xs() % 16);
    sep(k, 1'b0);
    rdchk(8'h10, k);
    // A sample edge keeps only the latest completed pair.
    c.arm_en = 1'b0;
    c.timing = TM_SAMPLE;
    run(c, 32'h0);
    sep(7, 1'b0);
    k = 3 + int'(xs() % 16);
    sep(k, 1'b0);
    encoder_source_inst.put(6, 1'b1, 6);
    encoder_source_inst.put(6, 1'b0, 6);
    rdchk(8'h18, k);
    // Falling edges, implicit timing, one pair more than the buffer holds.
    c.timing = TM_IMPLICIT;
    c.begin_edge_polarity = 1'b1;
    c.end_edge_polarity = 1'b1;
    encoder_source_inst.put(3, 1'b1, 0);
    encoder_source_inst.put(4, 1'b1, 6);
    run(c, 32'h0);
    repeat (17) begin
      k = 3 + int'(xs() % 16);
      if (q.size() < 16) q.push_back(k);
      sep(k, 1'b1);
    end
    rdchk(8'h14, 32'h85);
    while (q.size() > 0) rdchk(8'h18, q.pop_front());
    rdchk(8'h18, 32'h0);
    bus(8'h14, 1'b1, 32'h4);
    rdchk(8'h14, 32'h1);
    // Terminal timebase behind a falling arm edge, filter on; a short glitch must not tick.
    c.timing = TM_ON_DEMAND;
    c.arm_en = 1'b1;
    c.arm_edge = 1'b1;
    c.timebase_select = 1'b1;
    c.filter_en = 1'b1;
    run(c, 32'h0);
    encoder_source_inst.put(5, 1'b0, 8);
    k = 1 + int'(xs() % 4);
    encoder_source_inst.put(3, 1'b0, 8);
    repeat (k) begin
      encoder_source_inst.put(7, 1'b1, 5);
      encoder_source_inst.put(7, 1'b0, 5);
    end
    encoder_source_inst.put(7, 1'b1, 1);
    encoder_source_inst.put(7, 1'b0, 5);
    encoder_source_inst.put(4, 1'b0, 8);
    rdchk(8'h10, k);
    close_out();
  end

endmodule
